// >>> design/sgi_pkg.sv
// Constants, types and timing counts for the graphics DRAM start-up and self-refresh controller.
// Assumes a single 125 MHz system clock that also clocks the memory, and one memory device on the pins.
//
// Summary of operation
// - Round every nanosecond time up to cycles
// - Fast grade: 72/24/48 ns timings
// - Middle grade: 90/30/60 ns timings
// - Slow grade: 108/36/72 ns; mode set two clocks
// - Power-up: NOP, clock enable and masks high
// - Wait 200 us before first start command
// - Keep byte masks high during the pause
// - Precharge both banks, then mode register set
// - At least two auto-refreshes finish start-up
// - Self-refresh entry: select, strobes, enable low
// - Enable low at least activate-to-precharge time
// - Restart clock, let it settle, then raise enable
// - Enable stays high at least exit time
// - Exit starts with chip select high
// - Wait one row cycle after enable rises
// - Burst refresh 1024 before entry and after exit
// - Exit enable-high time is 8/10/12 ns
package sgi_pkg;

  // ****************************************
  // Clock and conversion
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;

  function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
    int unsigned r;
    r = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (r < 1) begin
      r = 1;
    end
    return r;
  endfunction

  // ****************************************
  // Speed grade timings in ns
  // ****************************************
  localparam int unsigned G8_TRC_NS   = 72;
  localparam int unsigned G8_TRP_NS   = 24;
  localparam int unsigned G8_TRRD_NS  = 16;
  localparam int unsigned G8_TRAS_NS  = 48;
  localparam int unsigned G8_TRSC_NS  = 8;
  localparam int unsigned G8_TSRX_NS  = 8;
  localparam int unsigned G10_TRC_NS  = 90;
  localparam int unsigned G10_TRP_NS  = 30;
  localparam int unsigned G10_TRAS_NS = 60;
  localparam int unsigned G10_TRSC_NS = 10;
  localparam int unsigned G10_TSRX_NS = 10;
  localparam int unsigned G12_TRC_NS  = 108;
  localparam int unsigned G12_TRP_NS  = 36;
  localparam int unsigned G12_TRAS_NS = 72;
  localparam int unsigned G12_TRSC_NS = 12;
  localparam int unsigned G12_TSRX_NS = 12;

  // ****************************************
  // Sequence figures
  // ****************************************
  localparam int unsigned PWRUP_US       = 200;
  localparam int unsigned PWRUP_CYC_DEF  = (PWRUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CLK_STABLE_NS  = 80;
  localparam logic [10:0] INIT_REF_CNT   = 11'h002;
  localparam logic [10:0] BURST_REF_CNT  = 11'h400;
  localparam int unsigned ADDR_W         = 9;
  localparam int unsigned DQM_W          = 4;
  localparam logic [8:0]  ADDR_PRE_ALL   = 9'h100;

  // ****************************************
  // Commands and states
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sgi_cmd_t;

  localparam sgi_cmd_t CMD_DESEL = 4'hf;
  localparam sgi_cmd_t CMD_NOP   = 4'h7;
  localparam sgi_cmd_t CMD_PRE   = 4'h2;
  localparam sgi_cmd_t CMD_MRS   = 4'h0;
  localparam sgi_cmd_t CMD_REF   = 4'h1;

  typedef enum logic [3:0] {
    S_PWR   = 4'h0,
    S_PRE   = 4'h1,
    S_PREW  = 4'h2,
    S_MRS   = 4'h3,
    S_MRSW  = 4'h4,
    S_REF   = 4'h5,
    S_REFW  = 4'h6,
    S_IDLE  = 4'h7,
    S_SRE   = 4'h8,
    S_SRH   = 4'h9,
    S_CLKON = 4'ha,
    S_SRX   = 4'hb
  } sgi_state_t;

  typedef enum logic [1:0] {
    PH_INIT = 2'h0,
    PH_PRE  = 2'h1,
    PH_POST = 2'h2
  } sgi_phase_t;

endpackage

// >>> design/sgi_ctrl.sv
// Host-side controller: power-up sequence and self-refresh entry/exit for a graphics DRAM.
// Assumes the memory shares sys_clk; mem_clk_en gates the memory clock outside this block.
`timescale 1ns/10ps
`default_nettype none
module sgi_ctrl
  import sgi_pkg::*;
#(
  parameter int GRADE     = 0,
  parameter int PWRUP_CYC = PWRUP_CYC_DEF
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [8:0]       mode_word,
  input  wire logic             burst_refresh,
  input  wire logic             sr_req,
  output logic                  init_done,
  output logic                  sr_active,
  output logic                  mem_clk_en,
  output logic                  mem_cke,
  output sgi_cmd_t              mem_cmd,
  output logic                  mem_bank,
  output logic [ADDR_W-1:0]     mem_addr,
  output logic [DQM_W-1:0]      mem_dqm
);

  // ****************************************
  // Cycle counts for the chosen grade
  // ****************************************
  localparam int TRC_CYC    = ns_to_cyc_up(GRADE == 0 ? G8_TRC_NS : GRADE == 1 ? G10_TRC_NS : G12_TRC_NS);
  localparam int TRP_CYC    = ns_to_cyc_up(GRADE == 0 ? G8_TRP_NS : GRADE == 1 ? G10_TRP_NS : G12_TRP_NS);
  localparam int TRAS_CYC   = ns_to_cyc_up(GRADE == 0 ? G8_TRAS_NS : GRADE == 1 ? G10_TRAS_NS : G12_TRAS_NS);
  localparam int TRSC_CYC   = ns_to_cyc_up(GRADE == 0 ? G8_TRSC_NS : GRADE == 1 ? G10_TRSC_NS : G12_TRSC_NS);
  localparam int TSRX_CYC   = ns_to_cyc_up(GRADE == 0 ? G8_TSRX_NS : GRADE == 1 ? G10_TSRX_NS : G12_TSRX_NS);
  localparam int STABLE_CYC = ns_to_cyc_up(CLK_STABLE_NS);
  localparam int TRC_M1     = TRC_CYC - 1;
  localparam int TSRX_M1    = TSRX_CYC - 1;

  // ****************************************
  // State
  // ****************************************
  sgi_state_t  state_reg;
  sgi_state_t  state_next;
  logic [15:0] timer_reg;
  logic [15:0] timer_next;
  logic [10:0] ref_cnt_reg;
  logic [10:0] ref_cnt_next;
  sgi_phase_t  phase_reg;
  sgi_phase_t  phase_next;
  logic        done_reg;
  logic        done_next;
  logic [10:0] ref_goal;
  logic        timer_end;

  assign ref_goal  = (phase_reg == PH_INIT) ? INIT_REF_CNT : BURST_REF_CNT;
  assign timer_end = (timer_reg <= 16'h0001);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_next   = state_reg;
    timer_next   = (timer_reg != 16'h0000) ? timer_reg - 16'h0001 : 16'h0000;
    ref_cnt_next = ref_cnt_reg;
    phase_next   = phase_reg;
    done_next    = done_reg;
    case (state_reg)
      S_PWR: begin
        if (timer_end) begin
          state_next = S_PRE;
        end
      end
      S_PRE: begin
        state_next = S_PREW;
        timer_next = 16'(TRP_CYC - 1);
      end
      S_PREW: begin
        if (timer_end) begin
          state_next = S_MRS;
        end
      end
      S_MRS: begin
        state_next = S_MRSW;
        timer_next = 16'(TRSC_CYC - 1);
      end
      S_MRSW: begin
        if (timer_end) begin
          state_next   = S_REF;
          ref_cnt_next = 11'h000;
          phase_next   = PH_INIT;
        end
      end
      S_REF: begin
        state_next   = S_REFW;
        ref_cnt_next = ref_cnt_reg + 11'h001;
        timer_next   = 16'(TRC_CYC - 1);
      end
      S_REFW: begin
        if (timer_end) begin
          if (ref_cnt_reg != ref_goal) begin
            state_next = S_REF;
          end else if (phase_reg == PH_PRE) begin
            state_next = S_SRE;
          end else begin
            state_next = S_IDLE;
            done_next  = 1'b1;
          end
        end
      end
      S_IDLE: begin
        if (sr_req) begin
          if (burst_refresh) begin
            state_next   = S_REF;
            ref_cnt_next = 11'h000;
            phase_next   = PH_PRE;
          end else begin
            state_next = S_SRE;
          end
        end
      end
      S_SRE: begin
        state_next = S_SRH;
        timer_next = 16'(TRAS_CYC - 1);
      end
      S_SRH: begin
        if (timer_end && !sr_req) begin
          state_next = S_CLKON;
          timer_next = 16'(STABLE_CYC);
        end
      end
      S_CLKON: begin
        if (timer_end) begin
          state_next = S_SRX;
          timer_next = 16'(TRC_CYC);
        end
      end
      S_SRX: begin
        if (timer_end) begin
          if (burst_refresh) begin
            state_next   = S_REF;
            ref_cnt_next = 11'h000;
            phase_next   = PH_POST;
          end else begin
            state_next = S_IDLE;
          end
        end
      end
      default: begin
        state_next = S_PWR;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_PWR;
      timer_reg <= 16'(PWRUP_CYC);
    end else if (ce) begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt_reg <= 11'h000;
      phase_reg   <= PH_INIT;
      done_reg    <= 1'b0;
    end else if (ce) begin
      ref_cnt_reg <= ref_cnt_next;
      phase_reg   <= phase_next;
      done_reg    <= done_next;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_cmd  <= CMD_NOP;
      mem_cke  <= 1'b1;
      mem_addr <= 9'h000;
      mem_bank <= 1'b0;
    end else if (ce) begin
      mem_bank <= 1'b0;
      mem_addr <= 9'h000;
      mem_cke  <= !(state_reg == S_SRE || state_reg == S_SRH || state_reg == S_CLKON);
      case (state_reg)
        S_PRE: begin
          mem_cmd  <= CMD_PRE;
          mem_addr <= ADDR_PRE_ALL;
        end
        S_MRS: begin
          mem_cmd  <= CMD_MRS;
          mem_addr <= mode_word;
        end
        S_REF: begin
          mem_cmd <= CMD_REF;
        end
        S_SRE: begin
          mem_cmd <= CMD_REF;
        end
        S_SRH, S_CLKON, S_SRX: begin
          mem_cmd <= CMD_DESEL;
        end
        default: begin
          mem_cmd <= CMD_NOP;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_clk_en <= 1'b1;
      mem_dqm    <= 4'hf;
      init_done  <= 1'b0;
      sr_active  <= 1'b0;
    end else if (ce) begin
      mem_clk_en <= (state_reg != S_SRH);
      mem_dqm    <= done_reg ? 4'h0 : 4'hf;
      init_done  <= done_reg;
      sr_active  <= (state_reg == S_SRE || state_reg == S_SRH || state_reg == S_CLKON || state_reg == S_SRX);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] since_rst_reg;
  logic [15:0] cke_low_reg;
  logic [1:0]  init_refs_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      since_rst_reg <= 16'h0000;
      cke_low_reg   <= 16'h0000;
      init_refs_reg <= 2'h0;
    end else if (ce) begin
      if (since_rst_reg != 16'hffff) begin
        since_rst_reg <= since_rst_reg + 16'h0001;
      end
      cke_low_reg <= mem_cke ? 16'h0000 : cke_low_reg + 16'h0001;
      if (!init_done && mem_cmd == CMD_REF && init_refs_reg != 2'h3) begin
        init_refs_reg <= init_refs_reg + 2'h1;
      end
    end
  end

  // ****************************************
  // Refresh spacing and burst tally
  // ****************************************
  logic [15:0] ref_gap_reg;
  logic [10:0] burst_refs_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_gap_reg <= 16'hffff;
    end else if (ce) begin
      if (mem_cmd == CMD_REF) begin
        ref_gap_reg <= 16'h0000;
      end else if (ref_gap_reg != 16'hffff) begin
        ref_gap_reg <= ref_gap_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_refs_reg <= 11'h000;
    end else if (ce) begin
      if (state_reg == S_IDLE || !mem_cke) begin
        burst_refs_reg <= 11'h000;
      end else if (mem_cmd == CMD_REF) begin
        burst_refs_reg <= burst_refs_reg + 11'h001;
      end
    end
  end

  default clocking dcb @(posedge sys_clk iff ce);
  endclocking
  default disable iff (!rst_b);

  AST_PWRUP_PINS: assert property (since_rst_reg < 16'(PWRUP_CYC) |->
    mem_cke && mem_clk_en && mem_dqm == 4'hf && mem_cmd == CMD_NOP)
    else $error("Power-up pins not idle");
  AST_PWRUP_WAIT: assert property (mem_cmd != CMD_NOP && mem_cmd != CMD_DESEL |->
    since_rst_reg >= 16'(PWRUP_CYC))
    else $error("Command before power-up pause ended");
  AST_DQM_INIT: assert property (!init_done |-> mem_dqm == 4'hf)
    else $error("Byte masks low before start-up done");
  AST_PRE_TO_MRS: assert property (mem_cmd == CMD_PRE |->
    ##[TRP_CYC:TRP_CYC] mem_cmd == CMD_MRS)
    else $error("Mode set not after precharge delay");
  AST_INIT_REFS: assert property ($rose(init_done) |-> init_refs_reg >= 2'h2)
    else $error("Start-up ended with fewer than two refreshes");
  AST_SR_ENTRY: assert property (mem_cmd == CMD_REF && !mem_cke |->
    $past(mem_cke) ##1 (!mem_clk_en && !mem_cke))
    else $error("Bad self-refresh entry");
  AST_SR_HOLD: assert property ($rose(mem_cke) |-> cke_low_reg >= 16'(TRAS_CYC))
    else $error("Clock enable low too short");
  AST_CLK_STABLE: assert property ($rose(mem_cke) |-> mem_clk_en && $past(mem_clk_en, STABLE_CYC))
    else $error("Clock not settled before exit");
  AST_SRX_DESEL: assert property ($rose(mem_cke) |->
    (mem_cke && mem_cmd == CMD_DESEL) throughout (##[TRC_M1:TRC_M1] 1'b1))
    else $error("Exit not held deselected for row cycle");
  AST_SRX_MIN: assert property ($rose(mem_cke) |=> mem_cke throughout (##[TSRX_M1:TSRX_M1] 1'b1))
    else $error("Clock enable high too short on exit");
  AST_WAIT_IDLE: assert property (state_reg == S_PREW || state_reg == S_MRSW || state_reg == S_REFW |=>
    mem_cmd == CMD_NOP)
    else $error("Command during wait interval");
  AST_PRE_ADDR: assert property (mem_cmd == CMD_PRE |-> mem_addr == ADDR_PRE_ALL)
    else $error("Precharge does not address both banks");
  AST_MRS_ADDR: assert property (mem_cmd == CMD_MRS |-> mem_addr == $past(mode_word))
    else $error("Mode word not on address pins");
  AST_REF_GAP: assert property (mem_cmd == CMD_REF |-> ref_gap_reg >= 16'(TRC_M1))
    else $error("Refreshes closer than a row cycle");
  AST_INIT_GAP: assert property ($rose(init_done) |-> ref_gap_reg >= 16'(TRC_M1))
    else $error("Start-up ended inside a refresh cycle");
  AST_DONE_KEEP: assert property (init_done |=> init_done)
    else $error("Start-up done flag dropped");
  AST_SR_FLAG: assert property (mem_cmd == CMD_REF && !mem_cke |-> sr_active)
    else $error("Self-refresh flag not raised on entry");
  AST_CLK_OFF_SR: assert property (!mem_clk_en |-> !mem_cke && mem_cmd == CMD_DESEL)
    else $error("Memory clock stopped outside self-refresh");
  AST_SR_DESEL: assert property (!mem_cke && !$past(mem_cke) |-> mem_cmd == CMD_DESEL)
    else $error("Command while in self-refresh");
  AST_BURST_PRE: assert property (mem_cmd == CMD_REF && !mem_cke |->
    burst_refs_reg == 11'h000 || burst_refs_reg == BURST_REF_CNT)
    else $error("Partial refresh burst before entry");
  AST_BURST_POST: assert property (state_reg == S_IDLE && phase_reg == PH_POST &&
    $past(state_reg) == S_REFW |-> burst_refs_reg == BURST_REF_CNT)
    else $error("Refresh burst after exit incomplete");

  COV_INIT: cover property ($rose(init_done));
  COV_SR_ENTER: cover property (mem_cmd == CMD_REF && !mem_cke);
  COV_SR_EXIT: cover property ($rose(mem_cke) && init_done);
  COV_BURST: cover property (state_reg == S_REF && phase_reg == PH_POST);
  COV_SR_PLAIN: cover property (mem_cmd == CMD_REF && !mem_cke && burst_refs_reg == 11'h000);

endmodule
`default_nettype wire

// >>> verif/sgi_dev_model.sv
// Behavioural memory device model: watches the command pins and counts timing slips.
// Assumes it shares sys_clk with the controller; mem_clk_en tells it the clock runs.
`timescale 1ns/10ps
`default_nettype none
module sgi_dev_model
  import sgi_pkg::*;
#(
  parameter int PWRUP_CYC = 20
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic             cke,
  input  wire sgi_cmd_t         cmd,
  input  wire logic [8:0]       addr,
  input  wire logic [3:0]       dqm,
  output logic                  in_sr,
  output logic [15:0]           viol
);
  // ****************************************
  // Device state
  // ****************************************
  logic [15:0] up_reg, gpre_reg, gref_reg, sr_reg, ex_reg;
  logic        pre_reg, mrs_reg;
  logic [1:0]  ir_reg;
  logic        ck;
  assign ck = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {up_reg, gpre_reg, gref_reg, sr_reg, viol} <= '0;
      ex_reg <= 16'hffff;
      {pre_reg, mrs_reg, in_sr, ir_reg} <= '0;
    end else if (in_sr) begin
      sr_reg <= sr_reg + 16'h1;
      gref_reg <= gref_reg + 16'h1;
      if (cke) begin
        in_sr <= 1'b0;
        ex_reg <= 16'h0;
        if (sr_reg < 16'h5 || !clk_en || !cmd.cs_n) viol <= viol + 16'h1;
      end
    end else begin
      up_reg <= up_reg + 16'h1;
      gpre_reg <= gpre_reg + 16'h1;
      gref_reg <= gref_reg + 16'h1;
      if (ex_reg != 16'hffff) ex_reg <= ex_reg + 16'h1;
      if (!clk_en || (ex_reg < 16'h8 && !cmd.cs_n) || (!cke && !ck) ||
          (ir_reg < 2'h2 && dqm != 4'hf) ||
          (cmd != CMD_NOP && cmd != CMD_DESEL && up_reg < PWRUP_CYC)) viol <= viol + 16'h1;
      if (cmd == CMD_PRE) begin
        gpre_reg <= 16'h0;
        pre_reg <= addr[8];
      end
      if (cmd == CMD_MRS) begin
        mrs_reg <= 1'b1;
        if (!pre_reg || gpre_reg < 16'h2) viol <= viol + 16'h1;
      end
      if (cmd == CMD_REF) begin
        gref_reg <= 16'h0;
        if (ir_reg != 2'h3) ir_reg <= ir_reg + 2'h1;
        if (!mrs_reg || gref_reg < 16'h8 || gpre_reg < 16'h2) viol <= viol + 16'h1;
      end
      if (!cke && ck) begin
        in_sr <= 1'b1;
        sr_reg <= 16'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/sgi_ctrl_tb_top.sv
// Self-checking bench for the start-up and self-refresh controller.
// Assumes the device model in verif/ and a shortened power-up pause.
`timescale 1ns/10ps
`default_nettype none
module sgi_ctrl_tb_top;
  import sgi_pkg::*;
  localparam int PW = 20;
  logic        sys_clk, rst_b, ce, burst_refresh, sr_req;
  logic [8:0]  mode_word, mem_addr;
  logic        init_done, sr_active, mem_clk_en, mem_cke, mem_bank, in_sr;
  sgi_cmd_t    mem_cmd;
  logic [3:0]  mem_dqm;
  logic [15:0] viol;
  int          failures, total_checks, n, i;
  sgi_ctrl #(.GRADE(0), .PWRUP_CYC(PW)) i_sgi_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
    .mode_word(mode_word), .burst_refresh(burst_refresh), .sr_req(sr_req), .init_done(init_done),
    .sr_active(sr_active), .mem_clk_en(mem_clk_en), .mem_cke(mem_cke), .mem_cmd(mem_cmd),
    .mem_bank(mem_bank), .mem_addr(mem_addr), .mem_dqm(mem_dqm));
  sgi_dev_model #(.PWRUP_CYC(PW)) i_sgi_dev_model (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(mem_clk_en),
    .cke(mem_cke), .cmd(mem_cmd), .addr(mem_addr), .dqm(mem_dqm), .in_sr(in_sr), .viol(viol));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_init();
    n = 0;
    while (mem_cmd !== CMD_PRE && n < 200) begin
      chk({mem_cke, mem_dqm, mem_cmd, mem_bank}, {1'b1, 4'hf, CMD_NOP, 1'b0});
      step();
      n++;
    end
    chk(n >= PW, 1'b1);
    chk(mem_addr, ADDR_PRE_ALL);
    for (i = 1; i <= 24; i++) begin
      step();
      chk(mem_cmd, i == 3 ? CMD_MRS : (i == 5 || i == 14) ? CMD_REF : CMD_NOP);
      if (i == 3) chk(mem_addr, mode_word);
      chk(init_done, i >= 23);
      chk(mem_dqm, i >= 23 ? 4'h0 : 4'hf);
    end
  endtask
  task automatic t_freeze();
    @(posedge sys_clk);
    ce <= 1'b0;
    sr_req <= 1'b1;
    repeat (6) begin
      step();
      chk({sr_active, mem_cke, mem_cmd}, {1'b0, 1'b1, CMD_NOP});
    end
    @(posedge sys_clk);
    ce <= 1'b1;
    sr_req <= 1'b0;
  endtask
  task automatic t_sr();
    @(posedge sys_clk);
    sr_req <= 1'b1;
    n = 0;
    do begin
      step();
      n++;
    end while (!(mem_cmd === CMD_REF && mem_cke === 1'b0) && n < 20);
    chk(n <= 3, 1'b1);
    chk(sr_active, 1'b1);
    for (i = 1; i <= 25; i++) begin
      @(posedge sys_clk);
      if (i == 1) sr_req <= 1'b0;
      #1;
      chk({mem_clk_en, mem_cke, sr_active}, {i >= 6, i >= 16, i < 25});
      chk(mem_cmd, i < 25 ? CMD_DESEL : CMD_NOP);
      if (i == 2) chk(in_sr, 1'b1);
    end
    chk(in_sr, 1'b0);
  endtask
  task automatic t_burst();
    @(posedge sys_clk);
    burst_refresh <= 1'b1;
    sr_req <= 1'b1;
    n = 0;
    for (i = 0; i < 12000 && !(mem_cmd === CMD_REF && mem_cke === 1'b0); i++) begin
      step();
      if (mem_cmd === CMD_REF && mem_cke === 1'b1) n++;
    end
    chk(n, 1024);
    @(posedge sys_clk);
    sr_req <= 1'b0;
    for (i = 0; i < 200 && sr_active !== 1'b0; i++) step();
    n = 0;
    repeat (9400) begin
      if (mem_cmd === CMD_REF) n++;
      step();
    end
    chk(n, 1024);
    @(posedge sys_clk);
    burst_refresh <= 1'b0;
  endtask
  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, burst_refresh, sr_req} = '0;
    ce = 1'b1;
    mode_word = 9'h0a5;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    step();
    t_init();
    t_freeze();
    t_sr();
    t_burst();
    chk(viol, 16'h0);
    close_out();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
